// [rtl/cbsb_pkg.sv]
// Shared constants, types and carriers of the bus snoop, back-off and ready unit
package cbsb_pkg;
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_APERR = 8'h08;
  localparam int CTRL_WBUF_MASK_BIT = 0;
  localparam int CTRL_TRISTATE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] APERR_RESET = 16'h0000;
  // Transfers
  localparam int BURST_BEATS = 4;
  localparam int LANES = 8;
  localparam int DATA_W = 64;
  // Strap default (weak pullups) and doubled ratio per strap code 000..111
  localparam logic [2:0] STRAP_DEFAULT = 3'h7;
  localparam logic [3:0] RATIO_X2_TABLE [8] = '{4'h9, 4'hA, 4'h8, 4'hB, 4'h5, 4'h6, 4'hC, 4'h7};

  typedef enum logic [2:0] {
    CYC_SINGLE = 3'b000,
    CYC_LINE_READ = 3'b001,
    CYC_WRITEBACK = 3'b010,
    CYC_SNOOP_WB = 3'b011,
    CYC_SPECIAL = 3'b100,
    CYC_INTACK = 3'b101
  } cbsb_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_XFER = 2'b10
  } cbsb_state_t;

  typedef struct packed {
    logic [31:3] addr;
    logic [7:0] lane_en_n;
    cbsb_kind_t kind;
    logic write;
    logic [255:0] line;
  } cbsb_req_t;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] dpar;
    logic [7:0] dpar_err;
    logic cacheable_n;
    logic wbsel;
    logic wbuf_empty_n;
    logic [1:0] beat;
  } cbsb_rsp_t;
endpackage : cbsb_pkg

// [rtl/cbsb_parity.sv]
// Address parity and per-lane data parity generation and checking
`timescale 1ns/1ps
module cbsb_parity
  import cbsb_pkg::*;
#(
  parameter int NUM_LANES = LANES
) (
  // Operands
  input wire logic [31:5] addr_in,
  input wire logic [NUM_LANES*8-1:0] data_in,
  input wire logic [NUM_LANES-1:0] lane_en_n_in,
  input wire logic [NUM_LANES-1:0] lane_par_in,
  // Results
  output logic addr_par_out,
  output logic [NUM_LANES-1:0] lane_par_out,
  output logic [NUM_LANES-1:0] lane_err_out
);
  if (NUM_LANES < 1) begin : g_bad
    $error("cbsb_parity needs at least one lane");
  end

  // Even parity over the line address only
  assign addr_par_out = ^addr_in;

  for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
    logic even;
    assign even = ^data_in[i*8 +: 8];
    // Disabled lanes neither generate nor flag
    assign lane_par_out[i] = lane_en_n_in[i] ? 1'b0 : even;
    assign lane_err_out[i] = !lane_en_n_in[i] && (even != lane_par_in[i]);
  end
endmodule : cbsb_parity

// [rtl/cbsb_ratio.sv]
// Clock-ratio strap capture at reset release and ratio decode
`timescale 1ns/1ps
module cbsb_ratio
  import cbsb_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Strap pins
  input wire logic [2:0] strap_in,
  // Captured values
  output logic [2:0] strap_out,
  output logic [3:0] ratio_x2_out
);
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic rst_d_ff;
  logic [2:0] strap_ff;
  logic [2:0] nxt_strap;

  always_comb begin
    nxt_strap = strap_ff;
    if (rst_d_ff && !rst_in) begin
      nxt_strap = sync2_ff;
    end
  end

  always_ff @(posedge clk_in) begin
    sync1_ff <= strap_in;
    sync2_ff <= sync1_ff;
    rst_d_ff <= rst_in;
    if (rst_in) begin
      strap_ff <= STRAP_DEFAULT;
    end else begin
      strap_ff <= nxt_strap;
    end
  end

  assign strap_out = strap_ff;
  assign ratio_x2_out = RATIO_X2_TABLE[strap_ff];
endmodule : cbsb_ratio

// [rtl/cbsb_bus_unit.sv]
// Bus cycle engine: strobes, address hold, parity, back-off, transfer ready, strap
// How it works
// [R1] Copy strobe mirrors cycle start strobe exactly
// [R2] Address hold floats address and parity only
// [R3] Under address hold, start only snoop writebacks
// [R4] Hold and back-off sampled every edge, even reset
// [R5] Even address parity over bits 31..5
// [R6] Snoop strobe samples address; bad parity flags
// [R7] Parity error one clock, edge after strobe
// [R8] Parity error output glitch-free, driven except test
// [R9] Parity held from cycle start, driven when idle
// [R10] Parity floats on hold, back-off, hold acknowledge
// [R11] Lane enables qualify bytes; lane parity
// [R12] System drives all lanes on burst reads
// [R13] Lane enables float on back-off, hold acknowledge
// [R14] Strap code maps to core clock ratio
// [R15] Strap captured at reset release only
// [R16] Back-off aborts cycle and floats the bus
// [R17] Aborted cycle restarts from first transfer
// [R18] Back-off beats ready on same edge
// [R19] Ready sampled from edge after strobe negation
// [R20] System asserts ready when data is done
// [R21] Ready edge captures data, cacheable, writeback select
// [R22] One ready per single cycle, four per burst
// [R23] Ready copy treated exactly like ready
// [R24] Cycle start strobe one clock per cycle
`timescale 1ns/1ps
module cbsb_bus_unit
  import cbsb_pkg::*;
#(
  parameter int BURST_LEN = BURST_BEATS
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  // Register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // Core request and response
  input wire logic REQ_VALID_IN,
  input wire cbsb_req_t REQ_IN,
  output logic REQ_READY_OUT,
  output logic RSP_VALID_OUT,
  output cbsb_rsp_t RSP_OUT,
  output logic DONE_OUT,
  output logic SNOOP_VALID_OUT,
  output logic [31:5] SNOOP_ADDR_OUT,
  // Address and parity pins
  output logic [31:3] ADDRESS_BUS_OUT,
  output logic ADDRESS_BUS_OE_OUT,
  input wire logic [31:5] ADDRESS_BUS_IN,
  output logic ADDRESS_PARITY_BIT_OUT,
  output logic ADDRESS_PARITY_OE_OUT,
  input wire logic ADDRESS_PARITY_BIT_IN,
  output logic ADDRESS_PARITY_ERROR_N_OUT,
  output logic ADDRESS_PARITY_ERROR_OE_OUT,
  // Strobes, lanes and cycle definition
  output logic CYCLE_START_STROBE_N_OUT,
  output logic CYCLE_START_STROBE_COPY_N_OUT,
  output logic STROBE_OE_OUT,
  output logic [7:0] BYTE_LANE_ENABLES_N_OUT,
  output logic CYCLE_WRITE_OUT,
  output logic LANE_OE_OUT,
  // Data pins
  output logic [63:0] DATA_OUT,
  output logic [7:0] DATA_PARITY_BITS_OUT,
  output logic DATA_OE_OUT,
  input wire logic [63:0] DATA_IN,
  input wire logic [7:0] DATA_PARITY_BITS_IN,
  // Control inputs from the system and the hold acknowledge
  input wire logic ADDRESS_HOLD_REQ_IN,
  input wire logic BUS_BACKOFF_N_IN,
  input wire logic TRANSFER_READY_N_IN,
  input wire logic TRANSFER_READY_COPY_N_IN,
  input wire logic NEXT_ADDRESS_REQ_N_IN,
  input wire logic SNOOP_ADDRESS_STROBE_N_IN,
  input wire logic CACHEABLE_ACK_N_IN,
  input wire logic WRITE_BUFFER_EMPTY_N_IN,
  input wire logic WRITEBACK_SELECT_IN,
  input wire logic BUS_HOLD_REQ_IN,
  output logic HOLD_ACK_OUT,
  // Strap
  input wire logic [2:0] CORE_RATIO_STRAP_IN,
  output logic [3:0] CORE_RATIO_X2_OUT
);
  if (BURST_LEN < 1 || BURST_LEN > BURST_BEATS) begin : g_bad
    $error("BURST_LEN must lie in 1..4");
  end
  localparam logic [1:0] LAST_BEAT = 2'(BURST_LEN - 1);

  cbsb_state_t state_ff, nxt_state;
  cbsb_req_t cur_ff, nxt_cur;
  cbsb_rsp_t rsp_ff, nxt_rsp;
  logic [1:0] beat_ff, nxt_beat;
  logic have_ff, nxt_have;
  logic burst_ff, nxt_burst;
  logic na_seen_ff, nxt_na_seen;
  logic cach_n_ff, nxt_cach_n;
  logic wbsel_ff, nxt_wbsel;
  logic strobe_n_ff, nxt_strobe_n;
  logic [31:3] addr_ff, nxt_addr;
  logic [7:0] lanes_ff, nxt_lanes;
  logic wr_ff, nxt_wr;
  logic [63:0] data_ff, nxt_data;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic done_ff, nxt_done;
  logic hold_ack_ff, nxt_hold_ack;
  logic addr_par_ff, nxt_addr_par;
  logic [7:0] dpar_ff, nxt_dpar;
  logic addr_oe_ff, nxt_addr_oe;
  logic bus_oe_ff, nxt_bus_oe;
  logic data_oe_ff, nxt_data_oe;
  logic address_parity_error_n_n_ff, nxt_address_parity_error_n_n;
  logic gap_ff, nxt_gap;
  logic snoop_v_ff, nxt_snoop_v;
  logic [31:5] snoop_addr_ff, nxt_snoop_addr;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [15:0] errcnt_ff, nxt_errcnt;
  logic [31:0] rdata_ff, nxt_rdata;
  logic backoff_now, ready_now, start_go, tristate, burst_eff, last_beat, use_cach_n;
  logic snoop_samp, snoop_err, chk_par, gen_par;
  logic [7:0] lane_err, gen_dpar;
  logic [1:0] nxt_idx;
  logic [2:0] strap;

  assign backoff_now = !BUS_BACKOFF_N_IN;
  assign ready_now = !TRANSFER_READY_N_IN || !TRANSFER_READY_COPY_N_IN; // [R23]
  assign tristate = ctrl_ff[CTRL_TRISTATE_BIT];
  // Address hold lets only a snoop writeback out
  assign start_go = have_ff && !backoff_now && !hold_ack_ff && !tristate
                    && (!ADDRESS_HOLD_REQ_IN || cur_ff.kind == CYC_SNOOP_WB); // [R3]
  assign burst_eff = (cur_ff.kind == CYC_LINE_READ && !na_seen_ff && beat_ff == 2'h0)
                     ? !CACHEABLE_ACK_N_IN : burst_ff; // [R22]
  assign last_beat = !burst_eff || beat_ff == LAST_BEAT; // [R22]
  assign use_cach_n = na_seen_ff ? cach_n_ff : CACHEABLE_ACK_N_IN; // [R21]
  assign nxt_idx = beat_ff + 2'h1;

  cbsb_parity #(.NUM_LANES(LANES)) u_chk (
    .addr_in(ADDRESS_BUS_IN),
    .data_in(DATA_IN),
    .lane_en_n_in(cur_ff.lane_en_n),
    .lane_par_in(DATA_PARITY_BITS_IN),
    .addr_par_out(chk_par),
    .lane_par_out(),
    .lane_err_out(lane_err)
  );

  cbsb_parity #(.NUM_LANES(LANES)) u_gen (
    .addr_in(nxt_addr[31:5]),
    .data_in(nxt_data),
    .lane_en_n_in(nxt_lanes),
    .lane_par_in(8'h00),
    .addr_par_out(gen_par),
    .lane_par_out(gen_dpar),
    .lane_err_out()
  );

  cbsb_ratio u_ratio (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .strap_in(CORE_RATIO_STRAP_IN),
    .strap_out(strap),
    .ratio_x2_out(CORE_RATIO_X2_OUT) // [R14] [R15]
  );

  // Bus cycle sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_rsp = rsp_ff;
    nxt_beat = beat_ff;
    nxt_have = have_ff;
    nxt_burst = burst_ff;
    nxt_na_seen = na_seen_ff;
    nxt_cach_n = cach_n_ff;
    nxt_wbsel = wbsel_ff;
    nxt_strobe_n = 1'b1; // [R24]
    nxt_addr = addr_ff;
    nxt_lanes = lanes_ff;
    nxt_wr = wr_ff;
    nxt_data = data_ff;
    nxt_rsp_valid = 1'b0;
    nxt_done = 1'b0;
    if (!have_ff && REQ_VALID_IN) begin
      nxt_have = 1'b1;
      nxt_cur = REQ_IN;
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (start_go) begin
          nxt_state = ST_START;
          nxt_strobe_n = 1'b0; // [R24]
          nxt_addr = cur_ff.addr; // [R9]
          nxt_lanes = cur_ff.lane_en_n; // [R11]
          nxt_wr = cur_ff.write;
          nxt_data = cur_ff.line[63:0];
          nxt_beat = 2'h0; // [R17]
          nxt_burst = cur_ff.kind == CYC_WRITEBACK || cur_ff.kind == CYC_SNOOP_WB;
          nxt_na_seen = 1'b0;
        end
      end
      ST_START: begin
        // Ready is not looked at on the edge that negates the strobe
        nxt_state = ST_XFER; // [R19]
      end
      ST_XFER: begin
        if (!NEXT_ADDRESS_REQ_N_IN && !na_seen_ff) begin
          nxt_na_seen = 1'b1;
          nxt_cach_n = CACHEABLE_ACK_N_IN; // [R21]
          nxt_wbsel = WRITEBACK_SELECT_IN;
          if (cur_ff.kind == CYC_LINE_READ) begin
            nxt_burst = !CACHEABLE_ACK_N_IN;
          end
        end
        if (ready_now) begin // [R19]
          nxt_rsp_valid = 1'b1;
          nxt_rsp.beat = beat_ff;
          nxt_rsp.data = wr_ff ? 64'h0 : DATA_IN; // [R21]
          nxt_rsp.dpar = wr_ff ? 8'h00 : DATA_PARITY_BITS_IN;
          nxt_rsp.dpar_err = wr_ff ? 8'h00 : lane_err; // [R11]
          nxt_rsp.cacheable_n = wr_ff ? 1'b1 : use_cach_n;
          nxt_rsp.wbsel = na_seen_ff ? wbsel_ff : WRITEBACK_SELECT_IN;
          nxt_rsp.wbuf_empty_n = (wr_ff && !ctrl_ff[CTRL_WBUF_MASK_BIT]) ? WRITE_BUFFER_EMPTY_N_IN : 1'b1;
          nxt_burst = burst_eff;
          nxt_beat = nxt_idx;
          nxt_data = cur_ff.line[64*nxt_idx +: 64];
          if (last_beat) begin // [R22]
            nxt_state = ST_IDLE;
            nxt_done = 1'b1;
            nxt_have = 1'b0;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Back-off wins over everything, including a ready on the same edge
    if (backoff_now) begin // [R16] [R18]
      nxt_state = ST_IDLE;
      nxt_strobe_n = 1'b1;
      nxt_rsp_valid = 1'b0;
      nxt_done = 1'b0;
      nxt_beat = 2'h0; // [R17]
      if (have_ff) begin
        nxt_have = 1'b1;
      end
    end
    nxt_addr_par = gen_par; // [R5]
    nxt_dpar = gen_dpar; // [R11]
  end

  // Hold acknowledge only from an idle bus
  always_comb begin
    nxt_hold_ack = BUS_HOLD_REQ_IN && (hold_ack_ff || (state_ff == ST_IDLE && !start_go));
    nxt_addr_oe = !(backoff_now || ADDRESS_HOLD_REQ_IN || nxt_hold_ack) && !tristate; // [R2] [R4] [R10]
    nxt_bus_oe = !(backoff_now || nxt_hold_ack) && !tristate; // [R13] [R16]
    nxt_data_oe = nxt_bus_oe && nxt_wr && nxt_state == ST_XFER;
  end

  // Snoop address parity check
  always_comb begin
    snoop_samp = !SNOOP_ADDRESS_STROBE_N_IN && !addr_oe_ff && !gap_ff; // [R6]
    snoop_err = snoop_samp && (chk_par != ADDRESS_PARITY_BIT_IN); // [R5]
    nxt_address_parity_error_n_n = !snoop_err; // [R7]
    nxt_gap = snoop_samp;
    nxt_snoop_v = snoop_samp;
    nxt_snoop_addr = snoop_samp ? ADDRESS_BUS_IN : snoop_addr_ff;
  end

  // Register file
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_errcnt = errcnt_ff;
    nxt_rdata = 32'h0;
    if (snoop_err && errcnt_ff != 16'hFFFF) begin
      nxt_errcnt = errcnt_ff + 16'h1;
    end
    if (REG_WR_IN && REG_ADDR_IN == REG_CTRL) begin
      nxt_ctrl = REG_WDATA_IN[1:0];
    end
    // A new error in the clearing cycle survives
    if (REG_WR_IN && REG_ADDR_IN == REG_APERR) begin
      nxt_errcnt = snoop_err ? 16'h1 : 16'h0;
    end
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        REG_CTRL: nxt_rdata = {30'h0, ctrl_ff};
        REG_STATUS: nxt_rdata = {18'h0, strap, CORE_RATIO_X2_OUT, state_ff, have_ff, hold_ack_ff, 1'b0,
                                 !bus_oe_ff, !addr_oe_ff};
        REG_APERR: nxt_rdata = {16'h0, errcnt_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  // Float control follows the inputs even while reset is held
  always_ff @(posedge CORE_CLK_IN) begin
    addr_oe_ff <= nxt_addr_oe;
    bus_oe_ff <= nxt_bus_oe;
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_ff <= ST_IDLE;
      cur_ff <= '0;
      rsp_ff <= '0;
      beat_ff <= 2'h0;
      have_ff <= 1'b0;
      burst_ff <= 1'b0;
      na_seen_ff <= 1'b0;
      cach_n_ff <= 1'b1;
      wbsel_ff <= 1'b0;
      strobe_n_ff <= 1'b1;
      addr_ff <= '0;
      lanes_ff <= 8'hFF;
      wr_ff <= 1'b0;
      data_ff <= 64'h0;
      rsp_valid_ff <= 1'b0;
      done_ff <= 1'b0;
      hold_ack_ff <= 1'b0;
      addr_par_ff <= 1'b0;
      dpar_ff <= 8'h00;
      data_oe_ff <= 1'b0;
      address_parity_error_n_n_ff <= 1'b1;
      gap_ff <= 1'b0;
      snoop_v_ff <= 1'b0;
      snoop_addr_ff <= '0;
      ctrl_ff <= CTRL_RESET;
      errcnt_ff <= APERR_RESET;
      rdata_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      rsp_ff <= nxt_rsp;
      beat_ff <= nxt_beat;
      have_ff <= nxt_have;
      burst_ff <= nxt_burst;
      na_seen_ff <= nxt_na_seen;
      cach_n_ff <= nxt_cach_n;
      wbsel_ff <= nxt_wbsel;
      strobe_n_ff <= nxt_strobe_n;
      addr_ff <= nxt_addr;
      lanes_ff <= nxt_lanes;
      wr_ff <= nxt_wr;
      data_ff <= nxt_data;
      rsp_valid_ff <= nxt_rsp_valid;
      done_ff <= nxt_done;
      hold_ack_ff <= nxt_hold_ack;
      addr_par_ff <= nxt_addr_par;
      dpar_ff <= nxt_dpar;
      data_oe_ff <= nxt_data_oe;
      address_parity_error_n_n_ff <= nxt_address_parity_error_n_n;
      gap_ff <= nxt_gap;
      snoop_v_ff <= nxt_snoop_v;
      snoop_addr_ff <= nxt_snoop_addr;
      ctrl_ff <= nxt_ctrl;
      errcnt_ff <= nxt_errcnt;
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA_OUT = rdata_ff;
  assign REQ_READY_OUT = !have_ff;
  assign RSP_VALID_OUT = rsp_valid_ff;
  assign RSP_OUT = rsp_ff;
  assign DONE_OUT = done_ff;
  assign SNOOP_VALID_OUT = snoop_v_ff;
  assign SNOOP_ADDR_OUT = snoop_addr_ff;
  assign ADDRESS_BUS_OUT = addr_ff;
  assign ADDRESS_BUS_OE_OUT = addr_oe_ff;
  assign ADDRESS_PARITY_BIT_OUT = addr_par_ff; // [R9]
  assign ADDRESS_PARITY_OE_OUT = addr_oe_ff; // [R10]
  assign ADDRESS_PARITY_ERROR_N_OUT = address_parity_error_n_n_ff; // [R8]
  assign ADDRESS_PARITY_ERROR_OE_OUT = !tristate; // [R8]
  assign CYCLE_START_STROBE_N_OUT = strobe_n_ff;
  assign CYCLE_START_STROBE_COPY_N_OUT = strobe_n_ff; // [R1]
  assign STROBE_OE_OUT = bus_oe_ff;
  assign BYTE_LANE_ENABLES_N_OUT = lanes_ff; // [R13]
  assign CYCLE_WRITE_OUT = wr_ff;
  assign LANE_OE_OUT = bus_oe_ff;
  assign DATA_OUT = data_ff;
  assign DATA_PARITY_BITS_OUT = dpar_ff;
  assign DATA_OE_OUT = data_oe_ff;
  assign HOLD_ACK_OUT = hold_ack_ff;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  sequence s_snoop_bad;
    !SNOOP_ADDRESS_STROBE_N_IN && !addr_oe_ff && !gap_ff && (chk_par != ADDRESS_PARITY_BIT_IN);
  endsequence
  sequence s_flag_pulse;
    !ADDRESS_PARITY_ERROR_N_OUT ##1 ADDRESS_PARITY_ERROR_N_OUT;
  endsequence

  a_copy_strobe_match: assert property (CYCLE_START_STROBE_COPY_N_OUT == CYCLE_START_STROBE_N_OUT) // [R1]
    else $error("strobe copy differs");
  a_hold_floats_addr: assert property (ADDRESS_HOLD_REQ_IN |=> !ADDRESS_BUS_OE_OUT && !ADDRESS_PARITY_OE_OUT) // [R2]
    else $error("address driven under hold");
  a_hold_only_wb: assert property (ADDRESS_HOLD_REQ_IN ##1 !CYCLE_START_STROBE_N_OUT |-> cur_ff.kind == CYC_SNOOP_WB) // [R3]
    else $error("cycle started under hold");
  a_snoop_parity_flag: assert property (s_snoop_bad |=> s_flag_pulse) // [R6]
    else $error("parity error flag wrong");
  a_flag_needs_cause: assert property ($fell(ADDRESS_PARITY_ERROR_N_OUT) |-> $past(snoop_err)) // [R7]
    else $error("spurious parity error");
  a_backoff_floats_bus: assert property (backoff_now |=> !STROBE_OE_OUT && !LANE_OE_OUT && !DATA_OE_OUT) // [R16]
    else $error("bus driven in back-off");
  a_backoff_wins_ready: assert property (backoff_now && ready_now && state_ff == ST_XFER
                                         |=> state_ff == ST_IDLE && !RSP_VALID_OUT && !DONE_OUT) // [R18]
    else $error("ready beat back-off");
  a_strobe_one_clock: assert property (!CYCLE_START_STROBE_N_OUT |=> CYCLE_START_STROBE_N_OUT && state_ff != ST_START) // [R24]
    else $error("strobe longer than one clock");
  a_restart_first_beat: assert property (!CYCLE_START_STROBE_N_OUT |-> beat_ff == 2'h0) // [R17]
    else $error("restart not at first transfer");
  a_flag_driven: assert property (!tristate |-> ADDRESS_PARITY_ERROR_OE_OUT) // [R8]
    else $error("parity error output floated");
endmodule : cbsb_bus_unit

// [verification/cbsb_chipset.sv]
// Behavioural system-side model answering bus cycles with ready beats
`timescale 1ns/1ps
module cbsb_chipset (
  // Clock and bus observation
  input wire logic clk_in,
  input wire logic strobe_n_in,
  input wire logic backoff_n_in,
  // Test control
  input wire logic [2:0] beats_in,
  input wire logic [1:0] waits_in,
  // Replies
  output logic rdy_n_out,
  output logic rdy_copy_n_out,
  output logic [63:0] data_out,
  output logic [7:0] dpar_out,
  output logic ken_n_out,
  output logic na_n_out,
  output logic write_buffer_empty_n_n_out,
  output logic wbsel_out
);
  int b;
  assign rdy_copy_n_out = rdy_n_out;
  // Cacheable answer whenever the test asks for a four-beat cycle
  assign ken_n_out = beats_in != 3'h4;
  assign na_n_out = 1'b1;
  assign write_buffer_empty_n_n_out = 1'b0;
  assign wbsel_out = 1'b1;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dpar_out[i] = ^data_out[i*8 +: 8];
    end
  end
  // Released data lines show the inverse of the last beat
  initial begin
    rdy_n_out = 1'b1;
    data_out = 64'h0;
    forever begin
      @(posedge clk_in);
      if (strobe_n_in === 1'b0) begin
        for (b = 0; b < beats_in; b++) begin
          repeat (waits_in) begin
            rdy_n_out <= 1'b1;
            data_out <= ~data_out;
            @(posedge clk_in);
          end
          rdy_n_out <= 1'b0;
          data_out <= {16{b[3:0] ^ 4'hA}};
          @(posedge clk_in);
          if (backoff_n_in === 1'b0) break;
        end
        rdy_n_out <= 1'b1;
        data_out <= ~data_out;
      end
    end
  end
endmodule : cbsb_chipset

// [verification/testbench.sv]
// Self-checking bench of the bus snoop, back-off and ready unit
`timescale 1ns/1ps
module testbench;
  import cbsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] ra = 8'h00;
  logic [31:0] rwd = 32'h0;
  logic [31:0] rdat;
  logic rwr = 1'b0, rrd = 1'b0, rv = 1'b0;
  cbsb_req_t rq = '0;
  cbsb_rsp_t rsp;
  logic rspv, done, aoe, apo, apoe, aperr_n, strb_n, strbc_n, soe, loe;
  logic rdy_n, rdyc_n, ken_n, na_n, write_buffer_empty_n_n, wbsel;
  logic [31:5] snaddr;
  logic [31:5] ain = 27'h0;
  logic ap_in = 1'b0, hold = 1'b0, bus_backoff_n_n = 1'b1, snoop_address_strobe_n_n = 1'b1;
  logic [2:0] strap = 3'h4;
  logic [2:0] beats = 3'h1;
  logic [1:0] waits = 2'h0;
  logic [3:0] rx2;
  logic [63:0] din;
  logic [7:0] dpin;
  logic [31:0] d;
  logic hreq = 1'b0;
  logic hold_ack, pcoe;
  int failures = 0, checked = 0, nrsp = 0, nstb = 0, n;
  cbsb_kind_t kinds [6] = '{CYC_SINGLE, CYC_LINE_READ, CYC_WRITEBACK, CYC_SNOOP_WB, CYC_SPECIAL, CYC_INTACK};
  int nbs [6] = '{1, 1, 4, 4, 1, 1};
  logic [5:0] wrs = 6'h1C;

  always #5 clk = ~clk;

  cbsb_bus_unit uut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(ra), .REG_WDATA_IN(rwd),
    .REG_WR_IN(rwr), .REG_RD_IN(rrd), .REG_RDATA_OUT(rdat), .REQ_VALID_IN(rv), .REQ_IN(rq),
    .REQ_READY_OUT(), .RSP_VALID_OUT(rspv), .RSP_OUT(rsp), .DONE_OUT(done), .SNOOP_VALID_OUT(),
    .SNOOP_ADDR_OUT(snaddr), .ADDRESS_BUS_OUT(), .ADDRESS_BUS_OE_OUT(aoe), .ADDRESS_BUS_IN(ain),
    .ADDRESS_PARITY_BIT_OUT(apo), .ADDRESS_PARITY_OE_OUT(apoe), .ADDRESS_PARITY_BIT_IN(ap_in),
    .ADDRESS_PARITY_ERROR_N_OUT(aperr_n), .ADDRESS_PARITY_ERROR_OE_OUT(pcoe),
    .CYCLE_START_STROBE_N_OUT(strb_n), .CYCLE_START_STROBE_COPY_N_OUT(strbc_n), .STROBE_OE_OUT(soe),
    .BYTE_LANE_ENABLES_N_OUT(), .CYCLE_WRITE_OUT(), .LANE_OE_OUT(loe), .DATA_OUT(),
    .DATA_PARITY_BITS_OUT(), .DATA_OE_OUT(), .DATA_IN(din), .DATA_PARITY_BITS_IN(dpin),
    .ADDRESS_HOLD_REQ_IN(hold), .BUS_BACKOFF_N_IN(bus_backoff_n_n), .TRANSFER_READY_N_IN(rdy_n),
    .TRANSFER_READY_COPY_N_IN(rdyc_n), .NEXT_ADDRESS_REQ_N_IN(na_n), .SNOOP_ADDRESS_STROBE_N_IN(snoop_address_strobe_n_n),
    .CACHEABLE_ACK_N_IN(ken_n), .WRITE_BUFFER_EMPTY_N_IN(write_buffer_empty_n_n), .WRITEBACK_SELECT_IN(wbsel),
    .BUS_HOLD_REQ_IN(hreq), .HOLD_ACK_OUT(hold_ack), .CORE_RATIO_STRAP_IN(strap), .CORE_RATIO_X2_OUT(rx2));

  cbsb_chipset sysm (.clk_in(clk), .strobe_n_in(strb_n), .backoff_n_in(bus_backoff_n_n), .beats_in(beats),
    .waits_in(waits), .rdy_n_out(rdy_n), .rdy_copy_n_out(rdyc_n), .data_out(din), .dpar_out(dpin),
    .ken_n_out(ken_n), .na_n_out(na_n), .write_buffer_empty_n_n_out(write_buffer_empty_n_n), .wbsel_out(wbsel));

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    #1 v = rdat;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    ra <= a;
    rwd <= v;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : wr

  task automatic run(input cbsb_kind_t k, input logic w, input int nb, input int ex);
    int n0;
    int i;
    @(posedge clk);
    n0 = nrsp;
    beats <= 3'(nb);
    rq <= '{addr: 29'h0123_4567, lane_en_n: 8'h00, kind: k, write: w, line: 256'h0};
    rv <= 1'b1;
    @(posedge clk);
    rv <= 1'b0;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
    if (i >= 200) failures++;
    #1;
    chk("response count", 64'(ex), 64'(nrsp - n0));
    if (!w) chk("read data", {16{4'(nb - 1) ^ 4'hA}}, rsp.data);
    if (!w) chk("lane parity flags", 64'h0, 64'(rsp.dpar_err));
  endtask : run

  always @(posedge clk) begin
    if (rspv === 1'b1) nrsp++;
    if (strb_n === 1'b0) nstb++;
    if (!rst) chk("strobe copy", {63'h0, strb_n}, {63'h0, strbc_n});
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    hold <= 1'b1;
    bus_backoff_n_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("addr oe in reset", 64'h0, 64'(aoe));
    chk("strobe oe in reset", 64'h0, 64'(soe));
    @(posedge clk);
    hold <= 1'b0;
    bus_backoff_n_n <= 1'b1;
    repeat (7) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    strap <= 3'h2;
    repeat (3) @(posedge clk);
    chk("ratio", 64'h5, 64'(rx2));
    rd(REG_STATUS, d);
    chk("status strap", 64'h4, 64'(d[13:11]));
    rd(8'h0C, d);
    chk("unmapped read", 64'h0, 64'(d));
    $display("test strap done");
    for (int k = 0; k < 6; k++) begin
      waits <= 2'(k % 2);
      run(kinds[k], wrs[k], nbs[k], nbs[k]);
    end
    run(CYC_LINE_READ, 1'b0, 4, 4);
    chk("cacheable", 64'h0, 64'(rsp.cacheable_n));
    chk("addr parity idle", 64'(^rq.addr[31:5]), 64'(apo));
    $display("test cycle kinds done");
    waits <= 2'h0;
    n = nrsp;
    fork
      run(CYC_WRITEBACK, 1'b1, 4, 7);
      begin
        wait (nrsp == n + 1);
        @(posedge clk);
        bus_backoff_n_n <= 1'b0;
        @(posedge clk);
        #1 chk("addr oe backoff", 64'h0, 64'(aoe));
        chk("strobe oe backoff", 64'h0, 64'(soe));
        @(posedge clk);
        bus_backoff_n_n <= 1'b1;
      end
    join
    $display("test backoff done");
    @(posedge clk);
    hold <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("addr oe hold", 64'h0, 64'(aoe));
    chk("parity oe hold", 64'h0, 64'(apoe));
    chk("lane oe hold", 64'h1, 64'(loe));
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      ain <= 27'h1;
      ap_in <= 1'(s);
      snoop_address_strobe_n_n <= 1'b0;
      @(posedge clk);
      snoop_address_strobe_n_n <= 1'b1;
      #1 chk("parity error", 64'(s), 64'(aperr_n));
      chk("snoop addr", 64'h1, 64'(snaddr));
      @(posedge clk);
      #1 chk("parity error end", 64'h1, 64'(aperr_n));
    end
    rd(REG_APERR, d);
    chk("error count", 64'h1, 64'(d));
    wr(REG_APERR, 32'h0);
    rd(REG_APERR, d);
    chk("error count cleared", 64'h0, 64'(d));
    run(CYC_SNOOP_WB, 1'b1, 4, 4);
    n = nstb;
    fork
      run(CYC_SINGLE, 1'b0, 1, 1);
      begin
        repeat (6) @(posedge clk);
        chk("strobe under hold", 64'(n), 64'(nstb));
        hold <= 1'b0;
      end
    join
    @(posedge clk);
    hreq <= 1'b1;
    @(posedge clk);
    #1 chk("hold ack", 64'h1, 64'(hold_ack));
    chk("parity oe hold ack", 64'h0, 64'(apoe));
    chk("lane oe hold ack", 64'h0, 64'(loe));
    @(posedge clk);
    hreq <= 1'b0;
    @(posedge clk);
    #1 chk("lane oe resumed", 64'h1, 64'(loe));
    chk("parity oe resumed", 64'h1, 64'(apoe));
    $display("test hold and snoop done");
    wr(REG_CTRL, 32'h2);
    rd(REG_CTRL, d);
    chk("ctrl readback", 64'h2, 64'(d));
    chk("flag oe test mode", 64'h0, 64'(pcoe));
    chk("lane oe test mode", 64'h0, 64'(loe));
    chk("addr oe test mode", 64'h0, 64'(aoe));
    wr(REG_CTRL, 32'h0);
    $display("test test mode done");
    conclude();
  end
endmodule : testbench
